// >>> shared/crce_pkg.sv
// How it works
// - each accepted feed write is folded into the running checksum
// - feed port takes byte, halfword or word writes; all four strobes fold a word, both low strobes a halfword, else one byte
// - busy reads one while data is pending or folding; checksum valid after
// - dma request only while engine enable and dma enable are both set
// - dma mode: busy clears only when idle and no dma words are queued
// - dma run ends: busy clears, checksum final, completion pulse to dma
// - control bit 16 is read-only busy
// - control bit 4 byte-swaps the checksum as read
// - control bit 3: zero low byte first, one high byte first
// - control bit 2: zero lsb-first shifting, one msb-first shifting
// - control bit 1 enables dma requests
// - control bit 0 enables the engine
// - 32-bit generator register resets to the reflected ethernet polynomial
// - every field returns to reset value on any reset
package crce_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_FEED = 4'h4;
    localparam logic [3:0] OFF_POLY = 4'h8;
    localparam logic [3:0] OFF_VAL = 4'hc;
    localparam int unsigned BIT_EN = 0;
    localparam int unsigned BIT_DMA = 1;
    localparam int unsigned BIT_MSB = 2;
    localparam int unsigned BIT_SWAP_IN = 3;
    localparam int unsigned BIT_SWAP_OUT = 4;
    localparam int unsigned BIT_BUSY = 16;
    localparam int unsigned CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [31:0] POLY_RST = 32'hedb8_8320;
    localparam logic [31:0] VAL_RST = 32'h0000_0000;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FEED_W = 34;
    localparam logic [1:0] LEN_BYTE = 2'h0;
    localparam logic [1:0] LEN_HALF = 2'h1;
    localparam logic [1:0] LEN_WORD = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } crce_state_e;
endpackage

// >>> rtl/crce_top.sv
`timescale 1ns/1ps
module crce_fifo #(
    parameter int unsigned WIDTH = 34,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW:0] wr_ptr_r;
    logic [PW:0] rd_ptr_r;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr_r - rd_ptr_r) != (PW+1)'(DEPTH);
    assign out_valid_o = wr_ptr_r != rd_ptr_r;
    assign out_data_o = mem_r[rd_ptr_r[PW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

module crce_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [crce_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [crce_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic dma_req_o,
    output logic dma_done_o
);
    logic rst_m_r;
    logic rst_n_r;
    logic [crce_pkg::CTRL_W-1:0] ctrl_r;
    logic [31:0] poly_r;
    logic [31:0] crc_r;
    logic aw_have_r;
    logic [crce_pkg::ADDR_W-1:0] aw_addr_r;
    logic w_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_mux;
    logic rd_hit;
    crce_pkg::crce_state_e state_r;
    logic [31:0] sh_r;
    logic [1:0] cnt_r;
    logic busy_q_r;
    logic dma_done_r;
    logic en;
    logic dma_en;
    logic busy;
    logic feed_hit;
    logic feed_take;
    logic wr_hit;
    logic wr_fire;
    logic push;
    logic fifo_in_ready;
    logic [crce_pkg::FEED_W-1:0] feed_word;
    logic [crce_pkg::FEED_W-1:0] fifo_out;
    logic fifo_out_valid;
    logic pop;
    logic [1:0] feed_len;
    logic [31:0] crc_byteswap;

    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_r);

    // two-flop release so every flop on rst_n_r leaves reset on the same edge
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    function automatic logic [31:0] crce_fold(
        input logic [31:0] crc,
        input logic [7:0] d,
        input logic [31:0] poly,
        input logic msb
    );
        logic [31:0] c;
        logic fb;
        c = crc;
        fb = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (msb)
            begin
                fb = c[31] ^ d[7-i];
                c = {c[30:0], 1'b0};
            end
            else
            begin
                fb = c[0] ^ d[i];
                c = {1'b0, c[31:1]};
            end
            if (fb)
            begin
                c = c ^ poly;
            end
        end
        return c;
    endfunction

    assign en = ctrl_r[crce_pkg::BIT_EN];
    assign dma_en = ctrl_r[crce_pkg::BIT_DMA];
    assign busy = (state_r == crce_pkg::ST_RUN) || fifo_out_valid;
    assign crc_byteswap = {crc_r[7:0], crc_r[15:8], crc_r[23:16], crc_r[31:24]};

    // write channel: address and data latched independently, any order
    assign s_axi_awready_o = !aw_have_r;
    assign s_axi_wready_o = !w_have_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign feed_hit = aw_addr_r == crce_pkg::OFF_FEED;
    // dma mode queues behind the fifo; software mode refuses while busy
    assign feed_take = en && (dma_en || !busy);
    assign wr_hit = (aw_addr_r == crce_pkg::OFF_CTRL) || feed_hit
        || (aw_addr_r == crce_pkg::OFF_POLY) || (aw_addr_r == crce_pkg::OFF_VAL);
    // a full fifo stalls the response, which stalls the dma source
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r
        && !(feed_hit && feed_take && !fifo_in_ready);
    assign push = wr_fire && feed_hit && feed_take;

    always_comb
    begin
        if (w_strb_r == 4'hf)
        begin
            feed_len = crce_pkg::LEN_WORD;
        end
        else if (w_strb_r[1:0] == 2'h3)
        begin
            feed_len = crce_pkg::LEN_HALF;
        end
        else
        begin
            feed_len = crce_pkg::LEN_BYTE;
        end
    end
    assign feed_word = {feed_len, w_data_r};

    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i;
            end
            else if (wr_fire)
            begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            else if (wr_fire)
            begin
                w_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= crce_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? crce_pkg::RESP_OKAY : crce_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready_i)
        begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ctrl_r <= crce_pkg::CTRL_RST;
            poly_r <= crce_pkg::POLY_RST;
        end
        else if (wr_fire)
        begin
            if (aw_addr_r == crce_pkg::OFF_CTRL && w_strb_r[0])
            begin
                ctrl_r <= w_data_r[crce_pkg::CTRL_W-1:0];
            end
            if (aw_addr_r == crce_pkg::OFF_POLY)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    if (w_strb_r[i])
                    begin
                        poly_r[8*i +: 8] <= w_data_r[8*i +: 8];
                    end
                end
            end
        end
    end

    // read channel
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr_i == crce_pkg::OFF_CTRL)
        begin
            rd_mux[crce_pkg::CTRL_W-1:0] = ctrl_r;
            rd_mux[crce_pkg::BIT_BUSY] = busy;
        end
        else if (s_axi_araddr_i == crce_pkg::OFF_POLY)
        begin
            rd_mux = poly_r;
        end
        else if (s_axi_araddr_i == crce_pkg::OFF_VAL)
        begin
            rd_mux = ctrl_r[crce_pkg::BIT_SWAP_OUT] ? crc_byteswap : crc_r;
        end
        else if (s_axi_araddr_i != crce_pkg::OFF_FEED)
        begin
            rd_hit = 1'b0;
        end
    end

    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= crce_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? crce_pkg::RESP_OKAY : crce_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready_i)
        begin
            rvalid_r <= 1'b0;
        end
    end

    crce_fifo #(
        .WIDTH(crce_pkg::FEED_W),
        .DEPTH(crce_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_r),
        .in_data_i(feed_word),
        .in_valid_i(push),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(state_r == crce_pkg::ST_IDLE)
    );

    assign pop = fifo_out_valid && (state_r == crce_pkg::ST_IDLE);

    // engine: one byte per cycle, so a word costs four cycles
    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= crce_pkg::ST_IDLE;
            sh_r <= 32'h0000_0000;
            cnt_r <= crce_pkg::LEN_BYTE;
        end
        else
        begin
            case (state_r)
                crce_pkg::ST_IDLE:
                begin
                    if (pop)
                    begin
                        state_r <= crce_pkg::ST_RUN;
                        cnt_r <= fifo_out[33:32];
                        if (!ctrl_r[crce_pkg::BIT_SWAP_IN])
                        begin
                            sh_r <= fifo_out[31:0];
                        end
                        else if (fifo_out[33:32] == crce_pkg::LEN_WORD)
                        begin
                            sh_r <= {fifo_out[7:0], fifo_out[15:8],
                                fifo_out[23:16], fifo_out[31:24]};
                        end
                        else if (fifo_out[33:32] == crce_pkg::LEN_HALF)
                        begin
                            sh_r <= {16'h0000, fifo_out[7:0], fifo_out[15:8]};
                        end
                        else
                        begin
                            sh_r <= fifo_out[31:0];
                        end
                    end
                end
                crce_pkg::ST_RUN:
                begin
                    sh_r <= {8'h00, sh_r[31:8]};
                    cnt_r <= cnt_r - 2'h1;
                    if (cnt_r == 2'h0)
                    begin
                        state_r <= crce_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= crce_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // the engine owns the checksum while folding; software writes only idle
    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            crc_r <= crce_pkg::VAL_RST;
        end
        else if (state_r == crce_pkg::ST_RUN)
        begin
            crc_r <= crce_fold(crc_r, sh_r[7:0], poly_r, ctrl_r[crce_pkg::BIT_MSB]);
        end
        else if (wr_fire && aw_addr_r == crce_pkg::OFF_VAL)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (w_strb_r[i])
                begin
                    crc_r[8*i +: 8] <= w_data_r[8*i +: 8];
                end
            end
        end
    end

    assign dma_req_o = en && dma_en && fifo_in_ready;
    assign dma_done_o = dma_done_r;

    always_ff @(posedge clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            busy_q_r <= 1'b0;
            dma_done_r <= 1'b0;
        end
        else
        begin
            busy_q_r <= busy;
            dma_done_r <= busy_q_r && !busy && en && dma_en;
        end
    end

    dma_gate_a: assert property (dma_req_o |-> en && dma_en)
        else $error("dma request without both enables");
    drop_off_a: assert property (wr_fire && feed_hit && !(en && (dma_en || !busy))
        |=> $stable(u_fifo.wr_ptr_r)) else $error("feed accepted while refused");
    fold_start_a: assert property (pop |=> state_r == crce_pkg::ST_RUN && busy)
        else $error("queued feed not folded");
    word_len_a: assert property (pop && fifo_out[33:32] == crce_pkg::LEN_WORD
        |=> (state_r == crce_pkg::ST_RUN)[*4] ##1 state_r == crce_pkg::ST_IDLE)
        else $error("word fold not four cycles");
    byte_len_a: assert property (pop && fifo_out[33:32] == crce_pkg::LEN_BYTE
        |=> state_r == crce_pkg::ST_RUN ##1 state_r == crce_pkg::ST_IDLE)
        else $error("byte fold not one cycle");
    busy_flag_a: assert property (push && !busy |-> ##2 busy)
        else $error("busy not raised after feed");
    busy_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o
        && s_axi_araddr_i == crce_pkg::OFF_CTRL
        |=> s_axi_rdata_o[crce_pkg::BIT_BUSY] == $past(busy))
        else $error("busy bit misread");
    swap_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o
        && s_axi_araddr_i == crce_pkg::OFF_VAL && ctrl_r[crce_pkg::BIT_SWAP_OUT]
        |=> s_axi_rdata_o[7:0] == $past(crc_r[31:24]))
        else $error("checksum not byte swapped");
    dma_done_a: assert property ($fell(busy) && en && dma_en |=> dma_done_o)
        else $error("dma completion missing");
    poly_reset_a: assert property ($rose(rst_n_r) |-> poly_r == crce_pkg::POLY_RST)
        else $error("generator reset value wrong");

    cov_dma_c: cover property (dma_done_o);
    cov_byte_c: cover property (pop && fifo_out[33:32] == crce_pkg::LEN_BYTE);
    cov_swap_c: cover property (pop && ctrl_r[crce_pkg::BIT_SWAP_IN]
        && fifo_out[33:32] == crce_pkg::LEN_WORD);
    cov_full_c: cover property (!fifo_in_ready);
endmodule

// >>> test/crce_host_model.sv
`timescale 1ns/1ps
module crce_host_model (
    input wire logic clk_i,
    output logic [3:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [3:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o,
    input wire logic dma_req_i,
    input wire logic dma_done_i
);
    int n_done = 0;
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    always @(posedge clk_i)
    begin
        if (dma_done_i === 1'b1)
            n_done <= n_done + 1;
    end
    // released address and data lines get inverted so a stale value is never mistaken for a fresh one
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= s;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awvalid_o && awready_i === 1'b1)
            begin
                awvalid_o <= 1'b0;
                awaddr_o <= ~a;
            end
            if (wvalid_o && wready_i === 1'b1)
            begin
                wvalid_o <= 1'b0;
                wdata_o <= ~d;
            end
        end while (bvalid_i !== 1'b1);
        bready_o <= 1'b0;
        r = bresp_i;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arvalid_o && arready_i === 1'b1)
            begin
                arvalid_o <= 1'b0;
                araddr_o <= ~a;
            end
        end while (rvalid_i !== 1'b1);
        rready_o <= 1'b0;
        d = rdata_i;
        r = rresp_i;
    endtask
    // dma side: one word per request, only while the engine asks for it
    task automatic dma_word(input logic [31:0] d);
        logic [1:0] r;
        while (dma_req_i !== 1'b1)
            @(posedge clk_i);
        wr(4'h4, d, 4'hf, r);
    endtask
endmodule

// >>> test/crc_engine_test.sv
`timescale 1ns/1ps
module crc_engine_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, v, e;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, dma_req, dma_done;
    logic [1:0] lens [3] = '{crce_pkg::LEN_BYTE, crce_pkg::LEN_HALF, crce_pkg::LEN_WORD};
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int nd;
    always #2 clk = ~clk;
    crce_top uut (
        .clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .dma_req_o(dma_req), .dma_done_o(dma_done)
    );
    crce_host_model m (
        .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready), .dma_req_i(dma_req), .dma_done_i(dma_done)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [1:0] q;
        m.wr(a, d, s, q);
    endtask
    // returns the first busy reading; bounded so a stuck flag ends the poll
    task automatic poll(output logic [31:0] first);
        logic [1:0] q;
        m.rd(4'h0, v, q);
        first = v;
        for (int i = 0; i < 50 && v[16] !== 1'b0; i++)
            m.rd(4'h0, v, q);
    endtask
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d,
        input logic [1:0] len, input logic [4:0] ctl, input logic [31:0] p);
        logic [7:0] b;
        logic fb;
        int n;
        n = int'(len) + 1;
        for (int k = 0; k < n; k++)
        begin
            b = ctl[3] ? d[8*(n-1-k) +: 8] : d[8*k +: 8];
            for (int i = 0; i < 8; i++)
            begin
                if (ctl[2])
                begin
                    fb = c[31] ^ b[7-i];
                    c = {c[30:0], 1'b0};
                end
                else
                begin
                    fb = c[0] ^ b[i];
                    c = {1'b0, c[31:1]};
                end
                if (fb)
                    c = c ^ p;
            end
        end
        return c;
    endfunction
    // one software pass; a second feed right behind the first must be dropped
    task automatic run(input logic [4:0] ctl, input logic [1:0] len, input logic [31:0] d,
        input logic drop2);
        logic [31:0] p, init, b, x;
        logic [3:0] s;
        logic [1:0] q;
        p = ctl[2] ? 32'h8005_0000 : 32'h0000_a001;
        init = ctl[2] ? 32'hffff_0000 : 32'h0000_ffff;
        s = (len == crce_pkg::LEN_WORD) ? 4'hf : (len == crce_pkg::LEN_HALF) ? 4'h3 : 4'h1;
        wr(4'h0, {27'h0, ctl & 5'h1e});
        wr(4'h8, p);
        wr(4'hc, init);
        wr(4'h0, {27'h0, ctl | 5'h01});
        wr(4'h4, d, s);
        if (drop2)
            wr(4'h4, ~d, s);
        poll(b);
        if (len == crce_pkg::LEN_WORD && !drop2)
            chk({31'h0, b[16]}, 32'h1);
        wr(4'h0, {27'h0, ctl & 5'h1e});
        x = fold(init, d, len, ctl, p);
        e = ctl[4] ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
        m.rd(4'hc, v, q);
        chk(v, e);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        m.rd(4'h0, v, r);
        chk(v, 32'h0);
        m.rd(4'h8, v, r);
        chk(v, 32'hedb8_8320);
        m.rd(4'hc, v, r);
        chk(v, 32'h0);
        m.rd(4'h2, v, r);
        chk({30'h0, r}, {30'h0, crce_pkg::RESP_SLVERR});
        m.wr(4'h2, 32'h0, 4'hf, r);
        chk({30'h0, r}, {30'h0, crce_pkg::RESP_SLVERR});
        m.wr(4'h0, 32'h0001_0000, 4'hf, r);
        chk({30'h0, r}, 32'h0);
        m.rd(4'h0, v, r);
        chk(v, 32'h0);
        for (int c = 0; c < 8; c++)
            for (int l = 0; l < 3; l++)
                run({c[2:0], 2'b00}, lens[l], 32'h1234_5678 ^ (c * 32'h0101_0101), 1'b0);
        run(5'h00, crce_pkg::LEN_WORD, 32'hcafe_f00d, 1'b1);
        wr(4'h0, 32'h0);
        wr(4'hc, 32'h5a5a_a5a5);
        wr(4'h4, 32'h1111_2222);
        m.rd(4'hc, v, r);
        chk(v, 32'h5a5a_a5a5);
        wr(4'h0, 32'h2);
        @(posedge clk);
        chk({31'h0, dma_req}, 32'h0);
        wr(4'h8, 32'hedb8_8320);
        wr(4'hc, 32'hffff_ffff);
        wr(4'h0, 32'h3);
        @(posedge clk);
        chk({31'h0, dma_req}, 32'h1);
        m.rd(4'h0, v, r);
        chk(v, 32'h3);
        nd = m.n_done;
        e = 32'hffff_ffff;
        for (int k = 0; k < 4; k++)
        begin
            m.dma_word(32'h0bad_0000 + k);
            e = fold(e, 32'h0bad_0000 + k, crce_pkg::LEN_WORD, 5'h03, 32'hedb8_8320);
        end
        for (int k = 0; k < 200 && m.n_done == nd; k++)
            @(posedge clk);
        chk({31'h0, m.n_done > nd}, 32'h1);
        m.rd(4'hc, v, r);
        chk(v, e);
        wr(4'h0, 32'h0000_001c);
        wr(4'h8, 32'h0000_8408);
        // second reset with the engine idle and fields dirtied: every field must come back
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        m.rd(4'h0, v, r);
        chk(v, 32'h0);
        m.rd(4'h8, v, r);
        chk(v, 32'hedb8_8320);
        m.rd(4'hc, v, r);
        chk(v, 32'h0);
        finish_test;
    end
    // whole run is about a thousand cycles; this only cuts a hang
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test;
        end
    end
endmodule
